// ### logic/spm_port.sv
// The APB register port and the register addresses were left to the implementer.
`default_nettype none

module spm_port (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic global_int_mask,
	output logic irq_request,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe_n,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe_n,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe_n,
	input wire logic ss_in,
	output logic ss_out,
	output logic ss_oe_n
);

	logic [7:0] ctrl_ff;
	logic [5:1] dir_ff;
	logic tcf_ff;
	logic write_collision_flag_ff;
	logic mode_fault_flag_ff;
	logic saw_tcf_ff;
	logic saw_write_collision_flag_ff;
	logic saw_mode_fault_flag_ff;
	logic [7:0] sh_ff;
	logic [7:0] rxbuf_ff;
	logic rx_bit_ff;
	logic [3:0] cnt_ff;
	logic [3:0] div_ff;
	logic sck_ff;
	logic sck_q_ff;
	logic [31:0] prdata_ff;
	spm_pkg::spm_state_t state_ff;

	logic en;
	logic master_select;
	logic clock_polarity;
	logic clock_phase;
	logic od;
	logic sel_ctrl;
	logic sel_stat;
	logic sel_data;
	logic sel_dir;
	logic acc;
	logic rd_acc;
	logic wr_acc;
	logic data_acc;
	logic data_wr;
	logic ctrl_wr;
	logic mode_fault_flag_ev;
	logic slave_sel;
	logic busy;
	logic write_collision_flag_ev;
	logic load;
	logic [3:0] half_m1;
	logic half_tick;
	logic lead;
	logic trail;
	logic rx;
	logic done;
	logic [7:0] nxt_byte;
	logic tcf_clr;
	logic [7:0] status_val;

	assign en = ctrl_ff[spm_pkg::CTL_SYS_EN];
	assign master_select = ctrl_ff[spm_pkg::CTL_MASTER];
	assign clock_polarity = ctrl_ff[spm_pkg::CTL_POL];
	assign clock_phase = ctrl_ff[spm_pkg::CTL_PHASE];
	assign od = ctrl_ff[spm_pkg::CTL_OPEN_DRAIN];

	assign sel_ctrl = (paddr == spm_pkg::OFF_CONTROL);
	assign sel_stat = (paddr == spm_pkg::OFF_STATUS);
	assign sel_data = (paddr == spm_pkg::OFF_DATA);
	assign sel_dir = (paddr == spm_pkg::OFF_DIRECTION);

	// Zero wait states: read data is captured in the setup cycle.
	assign pready = 1'b1;
	assign acc = psel & penable;
	assign rd_acc = acc & ~pwrite;
	assign wr_acc = acc & pwrite;
	assign pslverr = acc & ~(sel_ctrl | sel_stat | sel_data | sel_dir);
	assign prdata = prdata_ff;

	assign status_val = {tcf_ff, write_collision_flag_ff, 1'b0, mode_fault_flag_ff, 4'h0};

	assign data_acc = acc & sel_data;
	assign ctrl_wr = wr_acc & sel_ctrl;
	// A pending complete flag not yet seen by a status read blocks writes.
	assign data_wr = wr_acc & sel_data & ~(tcf_ff & ~saw_tcf_ff);

	// A master whose select pin is still an input watches it for contention.
	assign mode_fault_flag_ev = en & master_select & ~dir_ff[spm_pkg::DIR_SS] & ~ss_in;

	assign slave_sel = en & ~master_select & ~ss_in;

	// Phase 0 slave stays busy for as long as it is selected.
	always_comb begin
		if (master_select) begin
			busy = (state_ff == spm_pkg::ST_MASTER);
		end else if (!clock_phase) begin
			busy = slave_sel;
		end else begin
			busy = (state_ff == spm_pkg::ST_SLAVE);
		end
	end

	assign write_collision_flag_ev = data_wr & busy;
	assign load = data_wr & ~busy & ~mode_fault_flag_ev;

	always_comb begin
		case ({ctrl_ff[spm_pkg::CTL_RATE_HI], ctrl_ff[spm_pkg::CTL_RATE_LO]})
			2'b00: half_m1 = spm_pkg::HALF_M1_R0;
			2'b01: half_m1 = spm_pkg::HALF_M1_R1;
			2'b10: half_m1 = spm_pkg::HALF_M1_R2;
			default: half_m1 = spm_pkg::HALF_M1_R3;
		endcase
	end

	assign half_tick = (state_ff == spm_pkg::ST_MASTER) && (div_ff == half_m1);

	// Leading edge leaves the idle level; trailing edge returns to it.
	always_comb begin
		if (master_select) begin
			lead = half_tick & (sck_ff == clock_polarity);
			trail = half_tick & (sck_ff != clock_polarity);
		end else begin
			lead = slave_sel & ((sck_in ^ clock_polarity) & ~(sck_q_ff ^ clock_polarity));
			trail = slave_sel & (~(sck_in ^ clock_polarity) & (sck_q_ff ^ clock_polarity));
		end
	end

	assign rx = master_select ? miso_in : mosi_in;
	// Eighth trailing edge is the middle of the eighth clock cycle.
	assign done = trail & (cnt_ff == spm_pkg::LAST_BIT);
	assign nxt_byte = {sh_ff[6:0], clock_phase ? rx : rx_bit_ff};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			if (sel_ctrl) begin
				prdata_ff <= {24'h00_0000, ctrl_ff};
			end else if (sel_stat) begin
				prdata_ff <= {24'h00_0000, status_val};
			end else if (sel_data) begin
				prdata_ff <= {24'h00_0000, rxbuf_ff};
			end else if (sel_dir) begin
				prdata_ff <= {26'h000_0000, dir_ff, 1'b0};
			end else begin
				prdata_ff <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= spm_pkg::CONTROL_RESET;
		end else begin
			if (ctrl_wr) begin
				ctrl_ff <= pwdata[7:0];
			end
			if (mode_fault_flag_ev) begin
				ctrl_ff[spm_pkg::CTL_MASTER] <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_ff <= spm_pkg::DIRECTION_RESET;
		end else begin
			if (wr_acc && sel_dir) begin
				dir_ff <= pwdata[5:1];
			end
			if (mode_fault_flag_ev) begin
				dir_ff[5:2] <= 4'h0;
			end
		end
	end

	// Flags: a hardware set in the same cycle as a clear always wins.
	assign tcf_clr = data_acc & saw_tcf_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tcf_ff <= 1'b0;
		end else if (done) begin
			tcf_ff <= 1'b1;
		end else if (tcf_clr) begin
			tcf_ff <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_collision_flag_ff <= 1'b0;
		end else if (write_collision_flag_ev) begin
			write_collision_flag_ff <= 1'b1;
		end else if (data_acc && saw_write_collision_flag_ff) begin
			write_collision_flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_fault_flag_ff <= 1'b0;
		end else if (mode_fault_flag_ev) begin
			mode_fault_flag_ff <= 1'b1;
		end else if (ctrl_wr && saw_mode_fault_flag_ff) begin
			mode_fault_flag_ff <= 1'b0;
		end
	end

	// Remember which flags a status read returned, to arm their clears.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			saw_tcf_ff <= 1'b0;
			saw_write_collision_flag_ff <= 1'b0;
			saw_mode_fault_flag_ff <= 1'b0;
		end else begin
			if (rd_acc && sel_stat) begin
				saw_tcf_ff <= prdata_ff[spm_pkg::STA_COMPLETE];
				saw_write_collision_flag_ff <= prdata_ff[spm_pkg::STA_COLLISION];
				saw_mode_fault_flag_ff <= prdata_ff[spm_pkg::STA_FAULT];
			end else begin
				if (tcf_clr) begin
					saw_tcf_ff <= 1'b0;
				end
				if (data_acc) begin
					saw_write_collision_flag_ff <= 1'b0;
				end
				if (ctrl_wr) begin
					saw_mode_fault_flag_ff <= 1'b0;
				end
			end
		end
	end

	// An unread byte is kept; the newer one is lost on overrun.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxbuf_ff <= 8'h00;
		end else if (done && (!tcf_ff || tcf_clr)) begin
			rxbuf_ff <= nxt_byte;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= spm_pkg::ST_IDLE;
		end else begin
			case (state_ff)
				spm_pkg::ST_IDLE: begin
					if (load && master_select && en) begin
						state_ff <= spm_pkg::ST_MASTER;
					end else if (lead && !master_select) begin
						state_ff <= spm_pkg::ST_SLAVE;
					end
				end
				spm_pkg::ST_MASTER: begin
					if (done || mode_fault_flag_ev || !master_select || !en) begin
						state_ff <= spm_pkg::ST_IDLE;
					end
				end
				spm_pkg::ST_SLAVE: begin
					if (done || !slave_sel) begin
						state_ff <= spm_pkg::ST_IDLE;
					end
				end
				default: state_ff <= spm_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 4'h0;
		end else if (state_ff != spm_pkg::ST_MASTER || half_tick) begin
			div_ff <= 4'h0;
		end else begin
			div_ff <= div_ff + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_ff <= 1'b0;
		end else if (state_ff != spm_pkg::ST_MASTER) begin
			sck_ff <= clock_polarity;
		end else if (half_tick) begin
			sck_ff <= ~sck_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_q_ff <= 1'b0;
		end else begin
			sck_q_ff <= sck_in;
		end
	end

	// Counts trailing edges; a deselected slave restarts at bit 0.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 4'h0;
		end else if (done || (!master_select && !slave_sel)) begin
			cnt_ff <= 4'h0;
		end else if (master_select && state_ff != spm_pkg::ST_MASTER) begin
			cnt_ff <= 4'h0;
		end else if (trail) begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_bit_ff <= 1'b0;
		end else if (clock_phase ? trail : lead) begin
			rx_bit_ff <= rx;
		end
	end

	// Phase 0 shifts on trailing edges; phase 1 on later leading edges.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_ff <= 8'h00;
		end else if (load) begin
			sh_ff <= pwdata[7:0];
		end else if (done && !clock_phase) begin
			// Phase 1 keeps its last bit at the final edge for the hold time.
			sh_ff <= nxt_byte;
		end else if (!clock_phase && trail) begin
			sh_ff <= {sh_ff[6:0], rx_bit_ff};
		end else if (clock_phase && lead && cnt_ff != 4'h0) begin
			sh_ff <= {sh_ff[6:0], rx_bit_ff};
		end
	end

	assign irq_request = ctrl_ff[spm_pkg::CTL_INT_EN] & ~global_int_mask
		& (tcf_ff | mode_fault_flag_ff);

	// Pins: a driver is on only when enabled and its direction bit is set.
	// Open drain releases the pin instead of driving a one.
	always_comb begin
		logic drv_miso;
		logic drv_mosi;
		logic drv_sck;
		logic drv_ss;
		drv_miso = en & ~master_select & ~ss_in & dir_ff[spm_pkg::DIR_MISO];
		drv_mosi = en & master_select & dir_ff[spm_pkg::DIR_MOSI];
		drv_sck = en & master_select & dir_ff[spm_pkg::DIR_SCK];
		drv_ss = en & master_select & dir_ff[spm_pkg::DIR_SS];
		miso_out = sh_ff[7];
		mosi_out = sh_ff[7];
		sck_out = sck_ff;
		ss_out = dir_ff[spm_pkg::DIR_SS_LEVEL];
		miso_oe_n = ~(drv_miso & (~od | ~miso_out));
		mosi_oe_n = ~(drv_mosi & (~od | ~mosi_out));
		sck_oe_n = ~(drv_sck & (~od | ~sck_out));
		ss_oe_n = ~(drv_ss & (~od | ~ss_out));
	end

endmodule // spm_port

`default_nettype wire

// ### logic/spm_pkg.sv
// How it works
// - A master seeing its select input low sets the mode fault flag.
// - Master with direction bit 5 set drives select as output; no fault.
// - Phase 0 shifts on select OR clock; select rises between characters.
// - Phase 1 lets select stay low, even tied low for a single slave.
// - Mode fault clears master select and the four direction bits, not interrupt enable.
// - Data write during a transfer sets collision; byte dropped, transfer continues.
// - A master is busy from data write until transfer complete sets.
// - Phase 0 slave busy while selected; completes mid eighth clock cycle.
// - Phase 1 slave starts on first active clock edge, ends at completion.
// - Enabled interrupt on complete or fault unless globally masked.
// - System enable gives pins 2 to 5 to the port, except pin 5 of a master with direction bit 5 set.
// - Open drain select makes every port output open drain.
// - Master select chooses slave mode at 0 and master at 1.
// - Idle master clock rests at the polarity level.
// - Master rate select divides by 2, 4, 16 or 32.
// - Complete clears by status read then data access; writes blocked before.
// - Collision clears by status read seeing it, then data access.
// - Mode fault clears by status read seeing it, then control write.
// - Status bits 5 and 3 to 0 read as zero.
// - Only master data write starts a byte; both ends flag completion.
// - Received byte goes to a read buffer; uncleared flag means overrun.
// - Each byte takes exactly eight clock cycles, full duplex.
// - Unselected slave releases its master-in slave-out pin.
`default_nettype none

package spm_pkg;

	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_DIRECTION = 8'h0c;

	// Control fields.
	localparam int CTL_INT_EN = 7;
	localparam int CTL_SYS_EN = 6;
	localparam int CTL_OPEN_DRAIN = 5;
	localparam int CTL_MASTER = 4;
	localparam int CTL_POL = 3;
	localparam int CTL_PHASE = 2;
	localparam int CTL_RATE_HI = 1;
	localparam int CTL_RATE_LO = 0;

	// Status fields.
	localparam int STA_COMPLETE = 7;
	localparam int STA_COLLISION = 6;
	localparam int STA_FAULT = 4;

	// Direction register fields: pins 2..5 and the select output level.
	localparam int DIR_MISO = 2;
	localparam int DIR_MOSI = 3;
	localparam int DIR_SCK = 4;
	localparam int DIR_SS = 5;
	localparam int DIR_SS_LEVEL = 1;

	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [5:1] DIRECTION_RESET = 5'h00;

	// Clock dividers; the engine counts half periods minus one.
	localparam int DIV_R0 = 2;
	localparam int DIV_R1 = 4;
	localparam int DIV_R2 = 16;
	localparam int DIV_R3 = 32;
	localparam logic [3:0] HALF_M1_R0 = 4'(DIV_R0 / 2 - 1);
	localparam logic [3:0] HALF_M1_R1 = 4'(DIV_R1 / 2 - 1);
	localparam logic [3:0] HALF_M1_R2 = 4'(DIV_R2 / 2 - 1);
	localparam logic [3:0] HALF_M1_R3 = 4'(DIV_R3 / 2 - 1);

	localparam logic [3:0] LAST_BIT = 4'h7;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MASTER = 3'b010,
		ST_SLAVE = 3'b100
	} spm_state_t;

endpackage

`default_nettype wire

// ### testbench/spm_port_properties.sv
`default_nettype none
module spm_port_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic global_int_mask,
	input wire logic irq_request,
	input wire logic miso_oe_n,
	input wire logic mosi_out,
	input wire logic mosi_oe_n,
	input wire logic sck_out,
	input wire logic sck_oe_n,
	input wire logic ss_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ctl_ff;
	logic [4:0] quiet_ff;
	wire wr_ctl = psel && penable && pwrite && paddr == spm_pkg::OFF_CONTROL;
	// A fault clears master behind this mirror, so a set master bit here
	// only gates checks that a stale value cannot make fire.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctl_ff <= 8'h00;
		else if (wr_ctl)
			ctl_ff <= pwdata[7:0];
	end
	// A data write may start a byte, so the quiet count restarts at any data access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			quiet_ff <= 5'h00;
		else if (wr_ctl || $changed(sck_out) || psel && paddr == 8'h08)
			quiet_ff <= 5'h00;
		else if (quiet_ff != 5'h1f)
			quiet_ff <= quiet_ff + 5'h01;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	stat_zero_a: assert property (
		psel && penable && !pwrite && paddr == spm_pkg::OFF_STATUS
		|-> prdata[5] == 1'b0 && prdata[3:0] == 4'h0)
		else $error("status spare bits set");
	irq_mask_a: assert property (
		global_int_mask |-> !irq_request) else $error("irq while masked");
	irq_rise_a: assert property (
		$rose(irq_request) |-> ctl_ff[7]) else $error("irq while disabled");
	pins_off_a: assert property (
		!ctl_ff[6] |-> miso_oe_n && mosi_oe_n && sck_oe_n)
		else $error("pins driven while off");
	slave_pins_a: assert property (
		ctl_ff[6] && !ctl_ff[4] |-> mosi_oe_n && sck_oe_n)
		else $error("slave drives clock");
	miso_free_a: assert property (
		(!ctl_ff[4] && ss_in) [*3] |-> miso_oe_n)
		else $error("miso driven unselected");
	open_drain_a: assert property (
		ctl_ff[5] |-> (mosi_oe_n || !mosi_out) && (sck_oe_n || !sck_out))
		else $error("open drain drives high");
	sck_rest_a: assert property (
		ctl_ff[6] && ctl_ff[4] && !sck_oe_n && quiet_ff > 5'd16
		|-> sck_out == ctl_ff[3]) else $error("idle clock level");
endmodule // spm_port_props

bind spm_port spm_port_props i_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .global_int_mask, .irq_request,
	.miso_oe_n, .mosi_out, .mosi_oe_n, .sck_out, .sck_oe_n, .ss_in);
`default_nettype wire

// ### testbench/spm_slave_model.sv
`default_nettype none
module spm_slave_model (
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic clock_polarity,
	input wire logic clock_phase,
	input wire logic [7:0] tx,
	output logic miso,
	output logic [7:0] rx
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sh = 8'h00;
	initial miso = 1'b0;
	initial rx = 8'h00;
	// No pull-up on this line: a released pin shows the inverse, so a stale
	// bit cannot pass for data.
	always @(ss_n) begin
		if (!ss_n) begin
			sh = tx;
			if (!clock_phase)
				miso = tx[7];
		end else
			miso = ~miso;
	end
	always @(sck) begin
		if (!ss_n && (sck ^ clock_polarity) != clock_phase)
			rx = {rx[6:0], mosi};
		else if (!ss_n && clock_phase) begin
			miso = sh[7];
			sh = sh << 1;
		end else if (!ss_n) begin
			sh = sh << 1;
			miso = sh[7];
		end
	end
endmodule // spm_slave_model
`default_nettype wire

// ### testbench/spm_port_bench.sv
`default_nettype none
module spm_port_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] CTL = spm_pkg::OFF_CONTROL;
	localparam logic [7:0] STA = spm_pkg::OFF_STATUS;
	localparam logic [7:0] DAT = spm_pkg::OFF_DATA;
	localparam logic [7:0] DIR = spm_pkg::OFF_DIRECTION;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, global_int_mask = 1'b0, ext_ss = 1'b1;
	logic pol = 1'b0, pha = 1'b0, pready, pslverr, irq_request, err;
	logic miso_out, miso_oe_n, mosi_out, mosi_oe_n, sck_out, sck_oe_n;
	logic ss_out, ss_oe_n, slv_miso;
	logic [7:0] paddr = 8'h00, slv_tx = 8'h00, slv_rx;
	logic [31:0] pwdata = 32'h0, prdata, q;
	int n_mismatch = 0, checks_done = 0, edges = 0;
	int divs [4] = '{2, 4, 16, 32};
	time t0, t1;
	// Clock and mosi are pulled up so open-drain drive still reads high.
	wire miso_in = miso_oe_n ? slv_miso : miso_out;
	wire mosi_in = mosi_oe_n | mosi_out;
	wire sck_in = sck_oe_n | sck_out;
	wire ss_in = ss_oe_n ? ext_ss : ss_out;
	spm_port i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .global_int_mask, .irq_request,
		.miso_in, .miso_out, .miso_oe_n, .mosi_in, .mosi_out, .mosi_oe_n,
		.sck_in, .sck_out, .sck_oe_n, .ss_in, .ss_out, .ss_oe_n);
	spm_slave_model i_slave (.sck(sck_in), .ss_n(ss_in), .mosi(mosi_in),
		.clock_polarity(pol), .clock_phase(pha), .tx(slv_tx), .miso(slv_miso), .rx(slv_rx));
	always #20 pclk = ~pclk;
	always @(sck_in) begin
		if (edges == 0)
			t0 = $time;
		edges++;
		t1 = $time;
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, exp, input string m);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s: got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, d);
		apb(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(a, 1'b0, 8'h00);
	endtask
	task automatic setup(input logic [7:0] c, tx);
		pol = c[3];
		pha = c[2];
		slv_tx = tx;
		wr(DIR, 8'h3a);
		wr(CTL, c);
		wr(DIR, 8'h38);
		edges = 0;
	endtask
	task automatic wait_byte;
		for (int k = 0; k < 2000 && edges < 16; k++)
			@(posedge pclk);
	endtask
	task automatic t_regs;
		rd(CTL);
		check(q, 32'h0, "control reset");
		wr(CTL, 8'h4f);
		rd(CTL);
		check(q, 32'h4f, "slave setup");
		wr(STA, 8'hff);
		rd(STA);
		check(q, 32'h0, "status");
		rd(8'h10);
		check({q[31:1], err}, 32'h1, "unmapped");
		wr(DIR, 8'h04);
		wr(CTL, 8'h44);
		ext_ss <= 1'b0;
		@(posedge pclk);
		check(32'(miso_oe_n), 32'h0, "selected miso");
		ext_ss <= 1'b1;
		@(posedge pclk);
		check(32'(miso_oe_n), 32'h1, "released miso");
		wr(CTL, 8'h00);
		$display("t_regs done");
	endtask
	task automatic t_xfer;
		logic [7:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 8'(32'h50 + i % 4 + i / 4 * 4 + i % 2 * 8 + (i > 5) * 32);
			setup(c, 8'ha5 ^ 8'(i));
			wr(DAT, 8'h3c + 8'(i));
			wait_byte;
			check(32'(t1 - t0), 32'(15 * divs[i % 4] * 20), "rate");
			wr(DAT, 8'hff);
			rd(STA);
			check(q, 32'h80, "done");
			check(32'(sck_in), 32'(c[3]), "sck idle");
			rd(DAT);
			check(q, 32'(slv_tx), "rx byte");
			check(32'(slv_rx), 32'h3c + 32'(i), "tx byte");
			rd(STA);
			check(q, 32'h0, "cleared");
			check(32'(edges), 32'd16, "sck edges");
		end
		$display("t_xfer done");
	endtask
	task automatic t_coll;
		setup(8'hd3, 8'h81);
		wr(DAT, 8'hc3);
		wr(DAT, 8'h5a);
		rd(STA);
		check(q, 32'h40, "collision");
		check(32'(irq_request), 32'h0, "busy irq");
		wait_byte;
		rd(STA);
		check(q, 32'hc0, "both flags");
		check(32'(irq_request), 32'h1, "irq");
		check(32'(slv_rx), 32'hc3, "kept byte");
		rd(DAT);
		check(q, 32'h81, "rx");
		rd(STA);
		check(q, 32'h0, "cleared");
		$display("t_coll done");
	endtask
	task automatic t_fault;
		global_int_mask <= 1'b1;
		wr(DIR, 8'h18);
		wr(CTL, 8'hd0);
		ext_ss <= 1'b0;
		q = 32'h0;
		for (int k = 0; k < 8 && !q[4]; k++)
			rd(STA);
		check(q, 32'h10, "fault");
		check(32'(irq_request), 32'h0, "masked");
		global_int_mask <= 1'b0;
		@(posedge pclk);
		check(32'(irq_request), 32'h1, "irq");
		rd(CTL);
		check(q, 32'hc0, "master off");
		rd(DIR);
		check(q & 32'h3c, 32'h0, "pins off");
		ext_ss <= 1'b1;
		wr(CTL, 8'h00);
		rd(STA);
		check(q, 32'h0, "fault cleared");
		$display("t_fault done");
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_xfer;
		t_coll;
		t_fault;
		end_sim;
	end
	// Several times the longest expected run, so only a hang reaches it.
	initial begin
		repeat (40000) @(posedge pclk);
		n_mismatch++;
		end_sim;
	end
endmodule // spm_port_bench
`default_nettype wire
